/* File: bench/ucps_far_model.sv */
// Purpose: rocker switch and supply monitor on the far side
// Assumes: supply held as a level in millivolts
// Notes: comparator flags derived from that level
`timescale 1ns/1ns
module ucps_far_model #(
	parameter int CTL_MV = 800,
	parameter int LB_MV = 1050
) (
	// Clock
	input wire logic core_clk_in,
	// Switch pins
	output logic volume_adjust_out,
	output logic volume_down_input_out,
	// Supply flags
	output logic sup_above_0v6_out,
	output logic sup_above_0v95_out,
	output logic sup_above_1v1_out,
	output logic ctl_logic_ok_out,
	output logic low_batt_out
);
	int mv = 1300;
	initial begin
		volume_adjust_out = 1'b0;
		volume_down_input_out = 1'b0;
	end
	// Flags follow the modelled supply
	assign sup_above_0v6_out = (mv > 600);
	assign sup_above_0v95_out = (mv > 950);
	assign sup_above_1v1_out = (mv > 1100);
	assign ctl_logic_ok_out = (mv > CTL_MV);
	assign low_batt_out = (mv < LB_MV);
	task automatic supply(input int v);
		@(posedge core_clk_in);
		mv <= v;
	endtask
	task automatic hold(input logic up);
		@(posedge core_clk_in);
		if (up) begin
			volume_adjust_out <= 1'b1;
		end else begin
			volume_down_input_out <= 1'b1;
		end
	endtask
	task automatic release_sw();
		@(posedge core_clk_in);
		volume_adjust_out <= 1'b0;
		volume_down_input_out <= 1'b0;
	endtask
endmodule

/* File: bench/ucps_top_tb.sv */
// Purpose: self-checking bench for the supervisor top
// Assumes: fast tick and short repeat set by parameters
// Notes: register rows first, then hand-written sequences
`timescale 1ns/1ns
`include "ucps_regs.svh"
module ucps_top_tb;
	import ucps_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n;
	logic [4:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic up_pin, dn_pin, f06, f095, f11, ctl_ok, lowb;
	logic audio_en, hw_rst, ind_act, ind_fade, inj;
	logic [1:0] mem, tone;
	logic [4:0] vol;
	logic [3:0] ind_id;
	int mismatches = 0;
	int check_count = 0;
	logic [36:0] rows [6] = '{{5'h00, 32'h308}, {5'h04, 32'h0a051f}, {5'h08, 32'h64},
		{5'h10, 32'h10}, {5'h14, 32'h0}, {5'h1c, 32'h0}};
	always #5 core_clk = ~core_clk;
	ucps_far_model i_ucps_far_model (
		.core_clk_in(core_clk),
		.volume_adjust_out(up_pin),
		.volume_down_input_out(dn_pin),
		.sup_above_0v6_out(f06),
		.sup_above_0v95_out(f095),
		.sup_above_1v1_out(f11),
		.ctl_logic_ok_out(ctl_ok),
		.low_batt_out(lowb)
	);
	ucps_top #(.TICK_CYC(10), .LB_REPEAT_MS(5)) i_ucps_top (
		.core_clk_in(core_clk),
		.rst_n_in(rst_n),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.volume_adjust_in(up_pin),
		.volume_down_input_in(dn_pin),
		.sup_above_0v6_in(f06),
		.sup_above_0v95_in(f095),
		.sup_above_1v1_in(f11),
		.ctl_logic_ok_in(ctl_ok),
		.low_batt_in(lowb),
		.audio_en_out(audio_en),
		.hw_reset_out(hw_rst),
		.memory_select_out(mem),
		.volume_level_out(vol),
		.ind_active_out(ind_act),
		.ind_id_out(ind_id),
		.ind_tone_out(tone),
		.ind_fade_out(ind_fade),
		.ind_inject_input_out(inj)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic press(input logic up, input int n);
		i_ucps_far_model.hold(up);
		cyc(n);
		i_ucps_far_model.release_sw();
		cyc(6);
	endtask
	task automatic wait_audio();
		for (int i = 0; i < 12000; i++) begin
			if (audio_en === 1'b1) break;
			cyc(1);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		logic [31:0] d;
		rst_n = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		cyc(1);
		check(audio_en, 1'b0);
		check(hw_rst, 1'b0);
		i_ucps_far_model.hold(1'b1);
		foreach (rows[i]) begin
			reg_read(rows[i][36:32], d);
			check(d, rows[i][31:0]);
		end
		i_ucps_far_model.release_sw();
		reg_write(`UCPS_REG_IND, 32'h000a053f);
		cyc(2);
		check(inj, 1'b1);
		wait_audio();
		check(audio_en, 1'b1);
		check(vol, `UCPS_VOL_RST);
		cyc(2);
		check({ind_act, ind_id}, {1'b1, `UCPS_ID_PWRUP});
		// Volume mode: act on release only
		i_ucps_far_model.hold(1'b1);
		cyc(20);
		check(vol, 5'h10);
		i_ucps_far_model.release_sw();
		cyc(6);
		check(vol, 5'h11);
		check(ind_id, `UCPS_ID_VUP);
		press(1'b0, 20);
		check(vol, 5'h10);
		check(ind_id, `UCPS_ID_VDN);
		// Two short tones, then the indicator stops
		reg_write(`UCPS_REG_IND, 32'h0000a53f);
		press(1'b1, 20);
		check(ind_fade, 1'b1);
		cyc(600);
		check({ind_act, tone}, {1'b1, 2'h1});
		cyc(600);
		check(ind_act, 1'b0);
		reg_write(`UCPS_REG_IND, 32'h000a053f);
		press(1'b0, 20);
		check(vol, 5'h10);
		// Memory mode, four valid memories
		reg_write(`UCPS_REG_CTRL, 32'h309);
		press(1'b0, 20);
		check(mem, 2'h0);
		press(1'b1, 20);
		check(mem, 2'h1);
		check(vol, 5'h10);
		check(ind_id, `UCPS_ID_MEM0 + 4'h1);
		// Mixed mode, short does volume, one second threshold
		reg_write(`UCPS_REG_CTRL, 32'h30a);
		press(1'b1, 20);
		check(vol, 5'h11);
		i_ucps_far_model.hold(1'b1);
		cyc(9000);
		check(mem, 2'h1);
		check({ind_act, tone, ind_fade}, {1'b1, 2'h0, 1'b0});
		cyc(1100);
		check(mem, 2'h2);
		i_ucps_far_model.release_sw();
		cyc(6);
		check(vol, 5'h11);
		// Mixed mode, short does memory, long release does volume
		reg_write(`UCPS_REG_CTRL, 32'h30e);
		press(1'b0, 20);
		check(mem, 2'h1);
		press(1'b1, 20);
		check(mem, 2'h2);
		press(1'b1, 10100);
		check(mem, 2'h2);
		check(vol, 5'h12);
		// Shallow scheme
		i_ucps_far_model.supply(900);
		cyc(5);
		check(audio_en, 1'b0);
		i_ucps_far_model.supply(1000);
		cyc(5);
		check(audio_en, 1'b0);
		i_ucps_far_model.supply(1300);
		cyc(5);
		check(audio_en, 1'b1);
		i_ucps_far_model.supply(700);
		cyc(5);
		check(hw_rst, 1'b1);
		i_ucps_far_model.supply(1000);
		cyc(5);
		check(hw_rst, 1'b1);
		i_ucps_far_model.supply(1300);
		wait_audio();
		check(mem, 2'h2);
		i_ucps_far_model.supply(500);
		cyc(5);
		i_ucps_far_model.supply(1300);
		wait_audio();
		check({mem, vol}, {2'h0, 5'h10});
		// Deep scheme, memory mode
		reg_write(`UCPS_REG_CTRL, 32'h349);
		press(1'b1, 20);
		check(mem, 2'h1);
		i_ucps_far_model.supply(900);
		cyc(5);
		check(audio_en, 1'b0);
		i_ucps_far_model.supply(1300);
		cyc(20);
		check(audio_en, 1'b0);
		i_ucps_far_model.supply(500);
		cyc(5);
		check(mem, 2'h0);
		i_ucps_far_model.supply(1300);
		wait_audio();
		check(audio_en, 1'b1);
		i_ucps_far_model.supply(1000);
		cyc(8);
		check({ind_act, ind_id}, {1'b1, `UCPS_ID_LOWB});
		// Advanced scheme keeps audio at 0.95 V
		reg_write(`UCPS_REG_CTRL, 32'h389);
		i_ucps_far_model.supply(900);
		cyc(5);
		check(audio_en, 1'b1);
		// Reset in mid-run
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(2);
		check({audio_en, hw_rst, ind_act, inj, mem}, 6'h00);
		reg_read(`UCPS_REG_STAT, d);
		check(d, 32'h808);
		print_verdict();
	end
endmodule

/* File: hw/ucps_pkg.sv */
// Purpose: types shared by the supervisor files
// Assumes: field widths match the register header
// Notes: one packed struct carries all top-level state
package ucps_pkg;
	typedef enum logic [1:0] {UCPS_PW_OFF, UCPS_PW_DELAY, UCPS_PW_RUN, UCPS_PW_MUTE} ucps_pwr_t;
	typedef enum logic [1:0] {UCPS_RK_VOL, UCPS_RK_MEM, UCPS_RK_MIX, UCPS_RK_RSVD} ucps_rock_t;
	typedef enum logic [1:0] {UCPS_SC_SHALLOW, UCPS_SC_DEEP, UCPS_SC_ADV, UCPS_SC_RSVD} ucps_scheme_t;
	typedef struct packed {
		ucps_pwr_t pwr;
		logic [16:0] tick_cnt;
		logic tick;
		logic [9:0] ctrl;
		logic [21:0] ind_cfg;
		logic [7:0] por_dly;
		logic [4:0] vol;
		logic [1:0] mem;
		logic deep_drop;
		logic [11:0] por_ms;
		logic lb_seen;
		logic [18:0] lb_ms;
		logic [1:0] sw_prev;
		logic prs_act;
		logic prs_up;
		logic [12:0] prs_ms;
		logic prs_done;
		logic ind_act;
		logic [3:0] ind_id;
		logic [12:0] ind_ms;
		logic [12:0] tone_ms;
		logic [1:0] tone_idx;
		logic fade;
		logic [31:0] rdata;
		logic audio_en;
		logic hw_rst;
	} ucps_state_t;
endpackage

/* File: hw/ucps_regs.svh */
// Purpose: register map, field positions, reset values and timing figures
// Assumes: byte addresses on a 5-bit register port
// Notes: times in their own units; cycle counts derived in the top module
`ifndef UCPS_REGS_SVH
`define UCPS_REGS_SVH
`define UCPS_REG_CTRL 5'h00
`define UCPS_REG_IND 5'h04
`define UCPS_REG_POR 5'h08
`define UCPS_REG_STAT 5'h0c
`define UCPS_REG_VOL 5'h10
`define UCPS_CTRL_MODE 1:0
`define UCPS_CTRL_SHORT_MEM 2
`define UCPS_CTRL_LONG 5:3
`define UCPS_CTRL_SCHEME 7:6
`define UCPS_CTRL_NVALID 9:8
`define UCPS_CTRL_RST 10'h308
`define UCPS_IND_EN 4:0
`define UCPS_IND_INJ_IN 5
`define UCPS_IND_DUR 12:6
`define UCPS_IND_TONES 14:13
`define UCPS_IND_TLEN 21:15
`define UCPS_IND_RST 22'h0a051f
`define UCPS_POR_RST 8'h64
`define UCPS_VOL_RST 5'h10
`define UCPS_VOL_MAX 5'h1f
`define UCPS_VOL_MIN 5'h00
`define UCPS_ID_PWRUP 4'h0
`define UCPS_ID_LOWB 4'h1
`define UCPS_ID_VUP 4'h2
`define UCPS_ID_VDN 4'h3
`define UCPS_ID_VMAX 4'h4
`define UCPS_ID_VMIN 4'h5
`define UCPS_ID_MEM0 4'h6
`define UCPS_CLK_NS 10
`define UCPS_MS_NS 1000000
`define UCPS_FADE_MS 32
`define UCPS_DUR_UNIT_MS 50
`define UCPS_POR_UNIT_MS 10
`define UCPS_LONG_UNIT_MS 1000
`define UCPS_LONG_MIN 3'h1
`define UCPS_LONG_MAX 3'h5
`define UCPS_LB_REPEAT_MS 300000
`endif

/* File: hw/ucps_sync.sv */
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are slow levels from switches or comparators
// Notes: first stage feeds only the second stage; reset level per bit is the pin's idle level
`timescale 1ns/1ns
module ucps_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ucps_sync_st_t;
	ucps_sync_st_t s_r;
	ucps_sync_st_t s_nxt;
	generate
		if (W < 1) begin : g_chk
			$error("ucps_sync width must be at least one");
		end
	endgenerate
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = async_in;
		s_nxt.s2 = s_r.s1;
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= {RST_VAL, RST_VAL};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign sync_out = s_r.s2;
endmodule

/* File: hw/ucps_top.sv */
// Purpose: rocker switch, acoustic indicator control and supply supervision
// Assumes: supply comparator flags and switches arrive as async levels
// Notes: advanced scheme restarts like shallow; its gain steps live elsewhere
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "ucps_regs.svh"
// Summary of operation
// R1 - Three rocker modes: volume, memory, mixed
// R2 - Memory mode: up raises, down lowers memory
// R3 - Mixed: short/long threshold one to five seconds
// R4 - Setting picks which function short closures do
// R5 - Long memory change fires while still held
// R6 - Volume and memory modes act on release
// R7 - Ten indicators, each tied to one event
// R8 - Enables: single, memory group, volume groups
// R9 - Up to four faded tones, 6.35 s total
// R10 - Indicator injected at output or input
// R11 - Shallow, deep or advanced scheme, one active
// R12 - Audio held off for programmable power-up delay
// R13 - Presses during power-up delay are dropped
// R14 - Low battery gives audible warning
// R15 - Shallow: mute below 0.95 V until 1.1 V
// R16 - Shallow: ramp-down reset, off until 1.1 V
// R17 - Shallow: no 0.6 V drop keeps memory
// R18 - Shallow: 0.6 V drop reinitialises to memory A
// R19 - Deep: muted below 0.95 V until 0.6 V
// R20 - Deep: reset loads memory A, resumes above 1.1 V
// R21 - Up input raises gain, down input lowers
// R22 - Low battery indicator repeats every five minutes
// R23 - Supply levels come as comparator flags
// R24 - Memory steps stop at both ends
module ucps_top
	import ucps_pkg::*;
#(
	parameter int TICK_CYC = `UCPS_MS_NS / `UCPS_CLK_NS,
	parameter int LB_REPEAT_MS = `UCPS_LB_REPEAT_MS
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [4:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Rocker switch pins
	input wire logic volume_adjust_in,
	input wire logic volume_down_input_in,
	// Supply comparator flags
	input wire logic sup_above_0v6_in,
	input wire logic sup_above_0v95_in,
	input wire logic sup_above_1v1_in,
	input wire logic ctl_logic_ok_in,
	input wire logic low_batt_in,
	// Audio and indicator control
	output logic audio_en_out,
	output logic hw_reset_out,
	output logic [1:0] memory_select_out,
	output logic [4:0] volume_level_out,
	output logic ind_active_out,
	output logic [3:0] ind_id_out,
	output logic [1:0] ind_tone_out,
	output logic ind_fade_out,
	output logic ind_inject_input_out
);
	import ucps_pkg::*;

	localparam ucps_state_t ST_RST = '{pwr: UCPS_PW_DELAY, ctrl: `UCPS_CTRL_RST,
		ind_cfg: `UCPS_IND_RST, por_dly: `UCPS_POR_RST, vol: `UCPS_VOL_RST, default: '0};

	generate
		if (TICK_CYC < 2 || TICK_CYC > 131072 || LB_REPEAT_MS < 1 || LB_REPEAT_MS > 524288)
		begin : g_chk
			$error("ucps_top tick or repeat count out of range");
		end
	endgenerate

	ucps_state_t s_r;
	ucps_state_t s_nxt;
	logic [6:0] sync_q;
	logic up_q, dn_q, a06, a095, a11, ctl_ok, lowb;
	ucps_rock_t mode;
	ucps_scheme_t scheme;
	logic ev, do_vol, do_mem, held, long_hit, hard_rst;
	logic [3:0] evid;
	logic [1:0] nm;
	logic [12:0] thr_ms, dur_ms, tlen_ms;
	logic [11:0] por_ms_tgt;

	// Indicator enable groups
	function automatic logic ind_en(input logic [3:0] id, input logic [4:0] en);
		case (id)
			`UCPS_ID_PWRUP: ind_en = en[0];
			`UCPS_ID_LOWB: ind_en = en[1];
			`UCPS_ID_VUP, `UCPS_ID_VDN: ind_en = en[3];
			`UCPS_ID_VMAX, `UCPS_ID_VMIN: ind_en = en[4];
			4'h6, 4'h7, 4'h8, 4'h9: ind_en = en[2];
			default: ind_en = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] long_secs(input logic [2:0] f);
		if (f < `UCPS_LONG_MIN) long_secs = `UCPS_LONG_MIN;
		else if (f > `UCPS_LONG_MAX) long_secs = `UCPS_LONG_MAX;
		else long_secs = f;
	endfunction

	function automatic logic [1:0] mem_next(input logic [1:0] m, input logic up,
		input logic [1:0] top);
		if (up) mem_next = (m < top) ? m + 2'h1 : m;
		else mem_next = (m != 2'h0) ? m - 2'h1 : m;
	endfunction

	// Pins synchronised before use
	ucps_sync #(.W(7), .RST_VAL(7'h3c)) u_sync ( // R23
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in({low_batt_in, ctl_logic_ok_in, sup_above_1v1_in, sup_above_0v95_in,
			sup_above_0v6_in, volume_down_input_in, volume_adjust_in}),
		.sync_out(sync_q)
	);
	assign {lowb, ctl_ok, a11, a095, a06, dn_q, up_q} = sync_q; // R23

	always_comb begin
		s_nxt = s_r;
		mode = ucps_rock_t'(s_r.ctrl[`UCPS_CTRL_MODE]);
		scheme = ucps_scheme_t'(s_r.ctrl[`UCPS_CTRL_SCHEME]);
		ev = 1'b0;
		evid = 4'h0;
		do_vol = 1'b0;
		do_mem = 1'b0;
		nm = s_r.mem;
		thr_ms = 13'(long_secs(s_r.ctrl[`UCPS_CTRL_LONG])) * 13'(`UCPS_LONG_UNIT_MS); // R3
		dur_ms = 13'(s_r.ind_cfg[`UCPS_IND_DUR]) * 13'(`UCPS_DUR_UNIT_MS); // R9
		tlen_ms = 13'(s_r.ind_cfg[`UCPS_IND_TLEN]) * 13'(`UCPS_DUR_UNIT_MS);
		por_ms_tgt = 12'(s_r.por_dly) * 12'(`UCPS_POR_UNIT_MS);
		held = s_r.prs_up ? up_q : dn_q;
		long_hit = s_r.prs_ms >= thr_ms;
		// Millisecond enable
		if (s_r.tick_cnt == 17'(TICK_CYC - 1)) begin
			s_nxt.tick_cnt = 17'h0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 17'h1;
			s_nxt.tick = 1'b0;
		end
		// Register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				`UCPS_REG_CTRL: s_nxt.ctrl = reg_wdata_in[9:0]; // R1 R11
				`UCPS_REG_IND: s_nxt.ind_cfg = reg_wdata_in[21:0];
				`UCPS_REG_POR: s_nxt.por_dly = reg_wdata_in[7:0];
				`UCPS_REG_VOL: s_nxt.vol = reg_wdata_in[4:0]; // R2
				default: ;
			endcase
		end
		// Power sequencing
		case (s_r.pwr)
			UCPS_PW_OFF: begin
				if (!a06) s_nxt.deep_drop = 1'b1;
				if (a11 && ctl_ok) begin // R16 R20
					s_nxt.hw_rst = 1'b0;
					s_nxt.deep_drop = 1'b0;
					if (s_r.deep_drop || !a06) begin // R18
						s_nxt.mem = 2'h0;
						s_nxt.vol = `UCPS_VOL_RST;
						s_nxt.por_ms = 12'h0;
						s_nxt.pwr = UCPS_PW_DELAY;
					end else begin // R17
						s_nxt.pwr = UCPS_PW_RUN;
						s_nxt.audio_en = 1'b1;
					end
				end
			end
			UCPS_PW_DELAY: begin
				if (s_r.por_ms >= por_ms_tgt) begin // R12
					s_nxt.pwr = UCPS_PW_RUN;
					s_nxt.audio_en = 1'b1;
					ev = 1'b1;
					evid = `UCPS_ID_PWRUP;
				end else if (s_r.tick) begin
					s_nxt.por_ms = s_r.por_ms + 12'h1;
				end
			end
			UCPS_PW_RUN: begin
				if (!a095 && (scheme == UCPS_SC_SHALLOW || scheme == UCPS_SC_DEEP)) begin
					s_nxt.pwr = UCPS_PW_MUTE; // R15 R19
					s_nxt.audio_en = 1'b0;
				end
			end
			UCPS_PW_MUTE: begin
				if (a11 && scheme != UCPS_SC_DEEP) begin // R15
					s_nxt.pwr = UCPS_PW_RUN;
					s_nxt.audio_en = 1'b1;
				end
			end
			default: s_nxt.pwr = UCPS_PW_OFF;
		endcase
		// Rocker switch
		s_nxt.sw_prev = {dn_q, up_q};
		if (s_r.pwr != UCPS_PW_RUN) begin
			s_nxt.prs_act = 1'b0; // R13
		end else if (!s_r.prs_act) begin
			if ((up_q && !s_r.sw_prev[0]) || (dn_q && !s_r.sw_prev[1])) begin
				s_nxt.prs_act = 1'b1;
				s_nxt.prs_up = up_q && !s_r.sw_prev[0];
				s_nxt.prs_ms = 13'h0;
				s_nxt.prs_done = 1'b0;
			end
		end else if (held) begin
			if (s_r.tick && s_r.prs_ms != 13'h1fff) s_nxt.prs_ms = s_r.prs_ms + 13'h1;
			if (mode == UCPS_RK_MIX && !s_r.ctrl[`UCPS_CTRL_SHORT_MEM] && long_hit
				&& !s_r.prs_done) begin
				do_mem = 1'b1; // R5
				s_nxt.prs_done = 1'b1;
			end
		end else begin
			s_nxt.prs_act = 1'b0;
			if (!s_r.prs_done) begin
				case (mode)
					UCPS_RK_MEM: do_mem = 1'b1; // R2 R6
					UCPS_RK_MIX: begin
						if (s_r.ctrl[`UCPS_CTRL_SHORT_MEM] != long_hit) do_mem = 1'b1; // R4
						else do_vol = 1'b1;
					end
					default: do_vol = 1'b1; // R6
				endcase
			end
		end
		if (do_vol) begin
			ev = 1'b1;
			if (s_r.prs_up) begin // R21
				if (s_r.vol == `UCPS_VOL_MAX) evid = `UCPS_ID_VMAX;
				else begin
					s_nxt.vol = s_r.vol + 5'h1;
					evid = `UCPS_ID_VUP;
				end
			end else begin
				if (s_r.vol == `UCPS_VOL_MIN) evid = `UCPS_ID_VMIN;
				else begin
					s_nxt.vol = s_r.vol - 5'h1;
					evid = `UCPS_ID_VDN;
				end
			end
		end
		if (do_mem) begin
			nm = mem_next(s_r.mem, s_r.prs_up, s_r.ctrl[`UCPS_CTRL_NVALID]); // R24
			if (nm != s_r.mem) begin
				s_nxt.mem = nm;
				ev = 1'b1;
				evid = `UCPS_ID_MEM0 + {2'h0, nm};
			end
		end
		// Low battery warning and repeat
		if (s_r.pwr == UCPS_PW_RUN && lowb && !s_r.lb_seen) begin
			s_nxt.lb_seen = 1'b1; // R14
			s_nxt.lb_ms = 19'h0;
			ev = 1'b1;
			evid = `UCPS_ID_LOWB;
		end else if (s_r.lb_seen && s_r.tick) begin
			if (s_r.lb_ms == 19'(LB_REPEAT_MS - 1)) begin
				s_nxt.lb_ms = 19'h0; // R22
				ev = 1'b1;
				evid = `UCPS_ID_LOWB;
			end else begin
				s_nxt.lb_ms = s_r.lb_ms + 19'h1;
			end
		end
		// Indicator sequencing
		if (ev && ind_en(evid, s_r.ind_cfg[`UCPS_IND_EN])) begin // R7 R8
			s_nxt.ind_act = 1'b1;
			s_nxt.ind_id = evid;
			s_nxt.ind_ms = 13'h0;
			s_nxt.tone_ms = 13'h0;
			s_nxt.tone_idx = 2'h0;
		end else if (s_r.ind_act && s_r.tick) begin
			s_nxt.ind_ms = s_r.ind_ms + 13'h1;
			s_nxt.tone_ms = s_r.tone_ms + 13'h1;
			if (s_r.ind_ms + 13'h1 >= dur_ms) begin // R9
				s_nxt.ind_act = 1'b0;
			end else if (s_r.tone_ms + 13'h1 >= tlen_ms) begin
				s_nxt.tone_ms = 13'h0;
				if (s_r.tone_idx == s_r.ind_cfg[`UCPS_IND_TONES]) s_nxt.ind_act = 1'b0;
				else s_nxt.tone_idx = s_r.tone_idx + 2'h1;
			end
		end
		// Hardware reset entry
		hard_rst = (scheme == UCPS_SC_DEEP) ? !a06 : !ctl_ok; // R16 R19
		if (hard_rst && s_r.pwr != UCPS_PW_OFF) begin
			s_nxt.pwr = UCPS_PW_OFF;
			s_nxt.hw_rst = 1'b1;
			s_nxt.audio_en = 1'b0;
			s_nxt.deep_drop = !a06;
			s_nxt.prs_act = 1'b0;
			s_nxt.ind_act = 1'b0;
			s_nxt.lb_seen = 1'b0;
			if (scheme == UCPS_SC_DEEP) s_nxt.mem = 2'h0; // R20
		end
		s_nxt.fade = s_nxt.ind_act && (s_nxt.tone_ms < 13'(`UCPS_FADE_MS)
			|| s_nxt.tone_ms + 13'(`UCPS_FADE_MS) >= tlen_ms); // R9
		// Read data, one cycle after the strobe
		s_nxt.rdata = 32'h0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`UCPS_REG_CTRL: s_nxt.rdata = {22'h0, s_r.ctrl};
				`UCPS_REG_IND: s_nxt.rdata = {10'h0, s_r.ind_cfg};
				`UCPS_REG_POR: s_nxt.rdata = {24'h0, s_r.por_dly};
				`UCPS_REG_STAT: s_nxt.rdata = {20'h0, s_r.vol, s_r.ind_act, s_r.lb_seen,
					s_r.pwr, s_r.audio_en, s_r.mem};
				`UCPS_REG_VOL: s_nxt.rdata = {27'h0, s_r.vol};
				default: s_nxt.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_out = s_r.rdata;
	assign audio_en_out = s_r.audio_en;
	assign hw_reset_out = s_r.hw_rst;
	assign memory_select_out = s_r.mem;
	assign volume_level_out = s_r.vol;
	assign ind_active_out = s_r.ind_act;
	assign ind_id_out = s_r.ind_id;
	assign ind_tone_out = s_r.tone_idx;
	assign ind_fade_out = s_r.fade;
	assign ind_inject_input_out = s_r.ind_cfg[`UCPS_IND_INJ_IN]; // R10

	// Checks
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_delay_silent: assert property ((s_r.pwr == UCPS_PW_DELAY) |-> !s_r.audio_en) // R12
		else $error("audio enabled during power-up delay");
	chk_delay_no_press: assert property ((s_r.pwr != UCPS_PW_RUN) |=> !s_r.prs_act) // R13
		else $error("press kept outside run state");
	chk_shallow_mute: assert property ((s_r.pwr == UCPS_PW_RUN && scheme == UCPS_SC_SHALLOW
		&& !a095 && ctl_ok) |=> !s_r.audio_en) // R15
		else $error("shallow scheme did not mute");
	chk_shallow_off: assert property ((scheme == UCPS_SC_SHALLOW && !ctl_ok
		&& s_r.pwr != UCPS_PW_OFF) |=> (s_r.hw_rst && !s_r.audio_en)) // R16
		else $error("shallow ramp-down did not reset");
	chk_keep_memory: assert property ((s_r.pwr == UCPS_PW_OFF && a11 && ctl_ok && a06
		&& !s_r.deep_drop) |=> (s_r.pwr == UCPS_PW_RUN && s_r.mem == $past(s_r.mem))) // R17
		else $error("memory lost on shallow restart");
	chk_deep_reset: assert property ((scheme == UCPS_SC_DEEP && !a06 && s_r.pwr != UCPS_PW_OFF)
		|=> (s_r.pwr == UCPS_PW_OFF && s_r.mem == 2'h0)) // R20
		else $error("deep reset did not load memory A");
	chk_vol_on_release: assert property ((mode == UCPS_RK_VOL && s_r.prs_act && held
		&& !(reg_wr_in && reg_addr_in == `UCPS_REG_VOL)) |=> s_r.vol == $past(s_r.vol)) // R6
		else $error("volume changed while switch held");
	chk_mem_one_step: assert property ((s_r.pwr == UCPS_PW_RUN && $past(s_r.pwr) == UCPS_PW_RUN
		&& s_r.mem != $past(s_r.mem)) |-> (s_r.mem == $past(s_r.mem) + 2'h1
		|| s_r.mem == $past(s_r.mem) - 2'h1)) // R2
		else $error("memory moved by more than one");
	chk_ind_start: assert property ((ev && ind_en(evid, s_r.ind_cfg[`UCPS_IND_EN]) && !hard_rst)
		|=> (s_r.ind_act && s_r.ind_id == $past(evid))) // R7
		else $error("enabled indicator not started");
	chk_long_fire: assert property ((s_r.pwr == UCPS_PW_RUN && s_r.prs_act && held
		&& mode == UCPS_RK_MIX && !s_r.ctrl[`UCPS_CTRL_SHORT_MEM] && long_hit && !s_r.prs_done
		&& !hard_rst) |=> s_r.prs_done) // R5
		else $error("long press did not fire memory change");

	cov_long_mem: cover property (s_r.prs_act && held && $rose(s_r.prs_done));
	cov_deep_off: cover property (scheme == UCPS_SC_DEEP && $rose(s_r.hw_rst));
	cov_ind_play: cover property ($rose(s_r.ind_act));
	cov_unmute: cover property (s_r.pwr == UCPS_PW_MUTE ##1 s_r.pwr == UCPS_PW_RUN);
endmodule
